// *** rtl/hs_switch_pkg.sv ***
// package: register map, field layout, codes and timing for the high-side switch control
package hs_switch_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL_A     = 8'h00;
    localparam logic [7:0] OFS_CTRL_B     = 8'h04;
    localparam logic [7:0] OFS_SUPPLY_CFG = 8'h08;
    localparam logic [7:0] OFS_OC_STAT    = 8'h0C;
    localparam logic [7:0] OFS_OL_STAT    = 8'h10;
    localparam logic [7:0] OFS_SUP_STAT   = 8'h14;
    localparam logic [7:0] OFS_MODE       = 8'h18;
    localparam logic [7:0] OFS_OUT_STAT   = 8'h1C;

    // per-output configuration field: 3 bits, two outputs per control register
    localparam int CFG_W      = 3;
    localparam int CFG_LO_POS = 0;
    localparam int CFG_HI_POS = 4;

    // supply configuration bits
    localparam int OV_DIS_POS  = 0;
    localparam int UV_DIS_POS  = 1;
    localparam int REC_POS     = 2;
    // supply status bits
    localparam int SUP_OV_POS  = 0;
    localparam int SUP_UV_POS  = 1;

    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [2:0]  SUPPLY_RESET  = 3'h0;
    localparam logic [2:0]  STATUS_RESET  = 3'h0;

    // output configuration codes
    localparam logic [2:0] CFG_OFF    = 3'h0;
    localparam logic [2:0] CFG_ON     = 3'h1;
    localparam logic [2:0] CFG_TIMER1 = 3'h2;
    localparam logic [2:0] CFG_TIMER2 = 3'h3;
    localparam logic [2:0] CFG_PWM1   = 3'h4;
    localparam logic [2:0] CFG_PWM2   = 3'h5;

    // overcurrent filter time in ns and its cycle count at 40 MHz (rounded up)
    localparam int CLK_PERIOD_NS  = 25;
    localparam int OC_FILTER_NS   = 100000;
    localparam int OC_FILTER_CYC  = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OC_CNT_W       = 13;

    // chip operating modes
    typedef enum logic [4:0] {
        MODE_NORMAL    = 5'b00001,
        MODE_STOP      = 5'b00010,
        MODE_SLEEP     = 5'b00100,
        MODE_RESTART   = 5'b01000,
        MODE_FAILSAFE  = 5'b10000
    } chip_mode_e;

    // analog comparator inputs for one output
    typedef struct packed {
        logic overcurrent;
        logic open_load;
    } sense_s;

    // timer and pwm drive sources
    typedef struct packed {
        logic timer1;
        logic timer2;
        logic pwm1;
        logic pwm2;
    } source_s;

    function automatic logic source_level(input logic [2:0] code, input source_s src);
        logic lvl;
        lvl = 1'b0;
        case (code)
            CFG_ON:     lvl = 1'b1;
            CFG_TIMER1: lvl = src.timer1;
            CFG_TIMER2: lvl = src.timer2;
            CFG_PWM1:   lvl = src.pwm1;
            CFG_PWM2:   lvl = src.pwm2;
            default:    lvl = 1'b0;
        endcase
        return lvl;
    endfunction

endpackage

// *** rtl/hs_oc_filter.sv ***
// overcurrent filter: flags a trip after the condition holds for the filter time
`timescale 1ns/10ps
module hs_oc_filter
    import hs_switch_pkg::*;
#(
    parameter int FILTER_CYC = OC_FILTER_CYC
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    // condition
    input  wire logic active,
    input  wire logic over,
    // result
    output logic      trip
);
    logic [OC_CNT_W-1:0] count;
    wire                 counting = active && over;
    wire                 at_limit = (count == OC_CNT_W'(FILTER_CYC));

    // counter restarts whenever the condition drops, so glitches never trip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clk_en) begin
            if (!counting)
                count <= '0;
            else if (!at_limit)
                count <= count + OC_CNT_W'(1);
        end
    end

    assign trip = counting && at_limit;
endmodule // hs_oc_filter

// *** rtl/hs_switch_ctrl.sv ***
// high-side switch control: source select, supply and load protection, apb registers
// Behaviour
// - output follows direct, timer or pwm source
// - stop/sleep keep config, config writes ignored
// - restart or fail-safe turns all outputs off
// - overvoltage shutdown unless disabled, then reactivate
// - undervoltage shutdown unless disabled, then reactivate
// - recovery bit 1 restores, else clear config
// - supply faults set only supply flags
// - filtered overcurrent turns output off
// - overcurrent sets flag, config forced 000
// - overcurrent flags stay until software clears
// - open load checked only while on
// - open load keeps output on, flag sticky
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module hs_switch_ctrl
    import hs_switch_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // chip mode from the state machine
    input  wire chip_mode_e  chip_mode,
    // supply comparators
    input  wire logic        supply_ov,
    input  wire logic        supply_uv,
    // per-output sensing and sources
    input  wire sense_s [3:0] sense,
    input  wire source_s     sources,
    // switch gate drives
    output logic [3:0]       switch_output
);
    // configuration fields of the four outputs
    logic [2:0] cfg [4];
    logic [2:0] supply_cfg;
    logic [3:0] overcurrent_status;
    logic [3:0] open_load_status;
    logic [1:0] supply_status;

    wire overvoltage_shutdown_disable  = supply_cfg[OV_DIS_POS];
    wire undervoltage_shutdown_disable = supply_cfg[UV_DIS_POS];
    wire supply_fault_recovery         = supply_cfg[REC_POS];
    wire supply_overvoltage_flag       = supply_status[SUP_OV_POS];
    wire supply_undervoltage_flag      = supply_status[SUP_UV_POS];

    // bus decode
    wire        setup_ph   = psel && !penable;
    wire        access_ph  = psel && penable;
    wire        wr_access  = access_ph && pwrite && clk_en;
    wire        rd_access  = access_ph && !pwrite && clk_en;
    wire        hit_ctrl_a = (paddr == OFS_CTRL_A);
    wire        hit_ctrl_b = (paddr == OFS_CTRL_B);
    wire        hit_sup    = (paddr == OFS_SUPPLY_CFG);
    wire        hit_oc     = (paddr == OFS_OC_STAT);
    wire        hit_ol     = (paddr == OFS_OL_STAT);
    wire        hit_sstat  = (paddr == OFS_SUP_STAT);
    wire        hit_mode   = (paddr == OFS_MODE);
    wire        hit_out    = (paddr == OFS_OUT_STAT);
    wire        mapped     = hit_ctrl_a | hit_ctrl_b | hit_sup | hit_oc | hit_ol | hit_sstat | hit_mode | hit_out;
    wire        lane0      = pstrb[0];

    // mode gating: only normal mode accepts configuration
    wire        mode_normal  = (chip_mode == MODE_NORMAL);
    wire        mode_low     = (chip_mode == MODE_STOP) || (chip_mode == MODE_SLEEP);
    wire        mode_killed  = (chip_mode == MODE_RESTART) || (chip_mode == MODE_FAILSAFE);
    wire        cfg_wr_ok    = wr_access && lane0 && mode_normal;

    // supply shutdown
    wire        ov_shut      = supply_ov && !overvoltage_shutdown_disable;
    wire        uv_shut      = supply_uv && !undervoltage_shutdown_disable;
    wire        supply_shut  = ov_shut || uv_shut;
    logic       supply_shut_d;
    wire        supply_release = supply_shut_d && !supply_shut;
    wire        clear_on_release = supply_release && !supply_fault_recovery;

    // per-output logic
    logic [3:0] oc_trip;
    logic [3:0] next_on;
    logic [3:0] ol_event;
    logic [3:0] cfg_wr_hit;
    logic [2:0] wr_field [4];

    assign cfg_wr_hit[0] = cfg_wr_ok && hit_ctrl_a;
    assign cfg_wr_hit[1] = cfg_wr_ok && hit_ctrl_a;
    assign cfg_wr_hit[2] = cfg_wr_ok && hit_ctrl_b;
    assign cfg_wr_hit[3] = cfg_wr_ok && hit_ctrl_b;
    assign wr_field[0]   = pwdata[CFG_LO_POS +: CFG_W];
    assign wr_field[1]   = pwdata[CFG_HI_POS +: CFG_W];
    assign wr_field[2]   = pwdata[CFG_LO_POS +: CFG_W];
    assign wr_field[3]   = pwdata[CFG_HI_POS +: CFG_W];

    for (genvar i = 0; i < 4; i++) begin : g_out
        // source selection and shutdown gating
        assign next_on[i]  = source_level(cfg[i], sources) && !supply_shut && !mode_killed;
        assign ol_event[i] = switch_output[i] && sense[i].open_load;

        hs_oc_filter u_filter (
            .pclk    (pclk),
            .presetn (presetn),
            .clk_en  (clk_en),
            .active  (switch_output[i]),
            .over    (sense[i].overcurrent),
            .trip    (oc_trip[i])
        );

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg[i] <= CFG_OFF;
            end else if (clk_en) begin
                if (oc_trip[i] || clear_on_release)
                    cfg[i] <= CFG_OFF;
                else if (cfg_wr_hit[i])
                    cfg[i] <= wr_field[i];
            end
        end
    end

    // outputs freeze while clock enable is low; trip drops the drive at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_output <= 4'h0;
            supply_shut_d <= 1'b0;
        end else if (clk_en) begin
            switch_output <= next_on & ~oc_trip;
            supply_shut_d <= supply_shut;
        end
    end

    // sticky flags: event wins over a software clear
    wire [3:0] oc_clr = (wr_access && lane0 && hit_oc) ? pwdata[3:0] : 4'h0;
    wire [3:0] ol_clr = (wr_access && lane0 && hit_ol) ? pwdata[3:0] : 4'h0;
    wire [1:0] sp_clr = (wr_access && lane0 && hit_sstat) ? pwdata[1:0] : 2'h0;
    wire [1:0] sp_evt = {supply_uv, supply_ov};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overcurrent_status <= 4'h0;
            open_load_status   <= 4'h0;
            supply_status      <= 2'h0;
        end else if (clk_en) begin
            overcurrent_status <= (overcurrent_status & ~oc_clr) | oc_trip;
            open_load_status   <= (open_load_status & ~ol_clr) | ol_event;
            supply_status      <= (supply_status & ~sp_clr) | sp_evt;
        end
    end

    // supply configuration writable in normal mode only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            supply_cfg <= SUPPLY_RESET;
        else if (clk_en && cfg_wr_ok && hit_sup)
            supply_cfg <= pwdata[2:0];
    end

    // read mux
    wire [31:0] rd_word =
        hit_ctrl_a ? {25'h0, cfg[1], 1'b0, cfg[0]} :
        hit_ctrl_b ? {25'h0, cfg[3], 1'b0, cfg[2]} :
        hit_sup    ? {29'h0, supply_cfg} :
        hit_oc     ? {28'h0, overcurrent_status} :
        hit_ol     ? {28'h0, open_load_status} :
        hit_sstat  ? {30'h0, supply_undervoltage_flag, supply_overvoltage_flag} :
        hit_mode   ? {27'h0, chip_mode} :
        hit_out    ? {28'h0, switch_output} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (clk_en && setup_ph && !pwrite)
            prdata <= rd_word;
    end

    // zero-wait slave; stalls while the clock enable is low
    assign pready  = clk_en;
    assign pslverr = access_ph && !mapped;

    wire unused_ok = rd_access | mode_low;

    a_oc_forces_off: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && oc_trip[2] |=> cfg[2] == CFG_OFF && overcurrent_status[2] && !switch_output[2])
        else $error("overcurrent did not force output off");

    a_oc_trip_off: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && (|oc_trip) |=> (switch_output & $past(oc_trip)) == 4'h0)
        else $error("overcurrent trip left output on");

    a_killed_mode_off: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && mode_killed |=> switch_output == 4'h0)
        else $error("output on in restart or fail-safe");

    a_ov_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && supply_ov && !overvoltage_shutdown_disable |=> switch_output == 4'h0)
        else $error("overvoltage did not shut outputs");

    a_uv_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && supply_uv && !undervoltage_shutdown_disable |=> switch_output == 4'h0)
        else $error("undervoltage did not shut outputs");

    a_no_recover_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && supply_release && !supply_fault_recovery |=> cfg[2] == CFG_OFF)
        else $error("config kept without recovery");

    a_low_mode_hold: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && mode_low && !oc_trip[1] && !clear_on_release |=> $stable(cfg[1]))
        else $error("config changed in low-power mode");

    a_ol_keeps_on: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ol_event[2] && next_on[2] && !oc_trip[2] |=> open_load_status[2] && switch_output[2])
        else $error("open load not flagged or output dropped");

    a_ol_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && open_load_status[2] && ol_clr[2] == 1'b0 |=> open_load_status[2])
        else $error("open load flag dropped");

    a_oc_clear_blocked: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && oc_clr[3] && oc_trip[3] |=> overcurrent_status[3])
        else $error("overcurrent clear won over live fault");

    a_supply_only_flags: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && supply_ov && !(|oc_trip) && !(|ol_event) && oc_clr == 4'h0 |=>
        supply_overvoltage_flag && overcurrent_status == $past(overcurrent_status))
        else $error("supply fault touched other flags");

    a_direct_on: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && cfg[1] == CFG_ON && !supply_shut && !mode_killed && !oc_trip[1] |=> switch_output[1])
        else $error("direct on setting not applied");
endmodule // hs_switch_ctrl

// *** tb/hs_load_model.sv ***
// load model: switched loads that report overcurrent and open load while powered
`timescale 1ns/10ps
module hs_load_model
    import hs_switch_pkg::*;
(
    // gate drives
    input  wire logic   [3:0] switch_output,
    // load condition per output
    input  wire logic   [3:0] short_load,
    input  wire logic   [3:0] open_load,
    // sense comparators
    output sense_s      [3:0] sense
);
    // an unpowered load draws no current, so neither comparator can trip
    for (genvar k = 0; k < 4; k++) begin : g_load
        assign sense[k].overcurrent = switch_output[k] & short_load[k];
        assign sense[k].open_load   = switch_output[k] & open_load[k];
    end
endmodule // hs_load_model

// *** tb/hs_switch_ctrl_tb.sv ***
// testbench for the high-side switch control
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module hs_switch_ctrl_tb
    import hs_switch_pkg::*;
;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [3:0]  pstrb = 4'hF, short_c = 0, open_c = 0, switch_output;
    logic        pready, pslverr, err, supply_ov = 0, supply_uv = 0;
    logic [31:0] prdata;
    chip_mode_e  chip_mode = MODE_NORMAL;
    source_s     src = '0;
    sense_s      [3:0] sense;
    int          failures = 0, n_compared = 0;
    int          cfg_m [4] = '{0, 0, 0, 0};

    always #12.5 pclk = ~pclk;

    hs_switch_ctrl u_hs_switch_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .chip_mode(chip_mode),
        .supply_ov(supply_ov), .supply_uv(supply_uv), .sense(sense), .sources(src),
        .switch_output(switch_output));
    hs_load_model u_hs_load_model (.switch_output(switch_output), .short_load(short_c),
        .open_load(open_c), .sense(sense));

    task automatic cyc(int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rchk(string nm, logic [7:0] a, logic [31:0] ex);
        apb(0, a, 0);
        `CHK(nm, ex, rd)
    endtask
    // model keeps both fields of a control word, write sends the pair
    task automatic setcfg(int i, int code);
        cfg_m[i] = code;
        apb(1, i < 2 ? OFS_CTRL_A : OFS_CTRL_B, 32'(cfg_m[i & 2]) | (32'(cfg_m[i | 1]) << 4));
    endtask
    function automatic logic exp_lvl(int code, source_s s);
        case (code)
            1: return 1'b1;
            2: return s.timer1;
            3: return s.timer2;
            4: return s.pwm1;
            5: return s.pwm2;
            default: return 1'b0;
        endcase
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hE9C6));
        cyc(4);
        presetn <= 1;
        cyc(1);
        for (int a = 0; a < 8; a++)
            rchk("reset value", 8'(a * 4), a == 6 ? 32'h1 : 32'h0);
        apb(1, 8'h20, 32'hFFFF_FFFF);
        `CHK("unmapped error", 1'b1, err)
        rchk("unmapped read", 8'h20, 32'h0);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            src <= source_s'(4'($urandom));
            setcfg(c % 4, c);
            cyc(3);
            `CHK("source select", exp_lvl(c, src), switch_output[c % 4])
            setcfg(c % 4, 0);
        end
        pstrb <= 4'h0;
        apb(1, OFS_CTRL_A, 32'h1);
        pstrb <= 4'hF;
        rchk("masked write", OFS_CTRL_A, 32'h0);
        $display("test sources done");
        setcfg(1, 1);
        for (int m = 0; m < 2; m++) begin
            chip_mode <= m ? MODE_SLEEP : MODE_STOP;
            cyc(1);
            apb(1, OFS_CTRL_A, 32'h0);
            rchk("low power config", OFS_CTRL_A, 32'h10);
            `CHK("low power output", 4'h2, switch_output)
        end
        for (int m = 0; m < 2; m++) begin
            chip_mode <= m ? MODE_FAILSAFE : MODE_RESTART;
            cyc(3);
            `CHK("fault mode off", 4'h0, switch_output)
        end
        chip_mode <= MODE_NORMAL;
        cyc(3);
        `CHK("normal again", 4'h2, switch_output)
        $display("test modes done");
        apb(1, OFS_SUPPLY_CFG, 32'h4);
        supply_ov <= 1;
        cyc(3);
        `CHK("ov shutdown", 4'h0, switch_output)
        rchk("ov flag", OFS_SUP_STAT, 32'h1);
        rchk("no oc flag", OFS_OC_STAT, 32'h0);
        rchk("no ol flag", OFS_OL_STAT, 32'h0);
        supply_ov <= 0;
        cyc(3);
        `CHK("ov recovery", 4'h2, switch_output)
        apb(1, OFS_SUP_STAT, 32'h3);
        apb(1, OFS_SUPPLY_CFG, 32'h1);
        supply_ov <= 1;
        cyc(3);
        `CHK("ov disabled", 4'h2, switch_output)
        supply_ov <= 0;
        apb(1, OFS_SUPPLY_CFG, 32'h0);
        supply_uv <= 1;
        cyc(3);
        `CHK("uv shutdown", 4'h0, switch_output)
        rchk("supply flags", OFS_SUP_STAT, 32'h3);
        supply_uv <= 0;
        cyc(3);
        `CHK("no recovery", 4'h0, switch_output)
        cfg_m[1] = 0;
        rchk("config cleared", OFS_CTRL_A, 32'h0);
        $display("test supply done");
        setcfg(2, 1);
        setcfg(3, 1);
        short_c <= 4'h4;
        cyc(3900);
        `CHK("oc filtering", 4'hC, switch_output)
        cyc(200);
        `CHK("oc trip", 4'h8, switch_output)
        short_c <= 4'h0;
        rchk("oc flag", OFS_OC_STAT, 32'h4);
        cfg_m[2] = 0;
        rchk("oc config off", OFS_CTRL_B, 32'h10);
        cyc(100);
        rchk("oc flag sticky", OFS_OC_STAT, 32'h4);
        apb(1, OFS_OC_STAT, 32'h4);
        rchk("oc flag clear", OFS_OC_STAT, 32'h0);
        setcfg(2, 1);
        cyc(3);
        `CHK("oc reenable", 4'hC, switch_output)
        $display("test overcurrent done");
        open_c <= 4'h5;
        cyc(3);
        rchk("ol only when on", OFS_OL_STAT, 32'h4);
        `CHK("ol output stays", 4'hC, switch_output)
        apb(1, OFS_OL_STAT, 32'h4);
        rchk("ol clear refused", OFS_OL_STAT, 32'h4);
        open_c <= 4'h0;
        cyc(3);
        rchk("ol flag sticky", OFS_OL_STAT, 32'h4);
        apb(1, OFS_OL_STAT, 32'h4);
        rchk("ol flag clear", OFS_OL_STAT, 32'h0);
        $display("test open load done");
        // clear lands on the very edge at which the output 3 filter trips
        short_c <= 4'h8;
        cyc(3999);
        apb(1, OFS_OC_STAT, 32'h8);
        short_c <= 4'h0;
        rchk("oc clear refused", OFS_OC_STAT, 32'h8);
        `CHK("oc other output", 4'h4, switch_output)
        apb(1, OFS_OC_STAT, 32'h8);
        rchk("oc clear after", OFS_OC_STAT, 32'h0);
        $display("test overcurrent clear done");
        clk_en <= 1'b0;
        chip_mode <= MODE_RESTART;
        cyc(3);
        `CHK("frozen output", 4'h4, switch_output)
        `CHK("stalled ready", 1'b0, pready)
        clk_en <= 1'b1;
        cyc(2);
        `CHK("restart after freeze", 4'h0, switch_output)
        chip_mode <= MODE_NORMAL;
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(1);
        `CHK("reset output", 4'h0, switch_output)
        rchk("reset config", OFS_CTRL_B, 32'h0);
        rchk("reset oc flags", OFS_OC_STAT, 32'h0);
        $display("test freeze and reset done");
        tally_and_finish();
    end
endmodule // hs_switch_ctrl_tb
